// File: pmw_ctrl.sv
// Power-mode sequencer, wake-event collector, wake timers, pulse counters and APB registers
//
// The placing of the registers and register access over APB were chosen for this implementation.
module pmw_ctrl (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic [31:0]                o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic                  i_irq,
  input  wire logic                  i_radio_req,
  input  wire logic                  i_radio_rx_active,
  input  wire logic                  i_radio_tx_active,
  input  wire logic                  i_svm_ok,
  input  wire logic                  i_fosc_stable,
  input  wire logic                  i_slow_clk,
  input  wire logic                  i_comp,
  input  wire logic [1:0]            i_pulse,
  input  wire logic [pmw_pkg::NDIO-1:0] i_general_io_pin,
  output pmw_pkg::pmw_pwr_t          o_pwr,
  output logic                       o_flicker_out,
  output logic [pmw_pkg::NDIO-1:0]   o_flicker_pin_sel
);
  localparam int N = pmw_pkg::NDIO;
  localparam int TW = pmw_pkg::TMR_W;
  localparam int PW = pmw_pkg::PC_W;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [N-1:0]                dio_s1_q, dio_s2_q, dio_s3_q;
  logic [5:0]                  x_s1_q, x_s2_q, x_s3_q;
  logic [pmw_pkg::CTRL_W-1:0]  ctrl_q;
  logic [pmw_pkg::NWEN-1:0]    wen_q;
  logic [pmw_pkg::NEVT-1:0]    epend_q, evt_set, eclr;
  logic [N-1:0]                dpend_q, den_q, dedge_q, dio_det, dclr;
  logic [TW-1:0]               tcnt_q [2];
  logic [TW-1:0]               tcmp_q [2];
  logic [PW-1:0]               pcnt_q [2];
  logic [PW-1:0]               ptgt_q [2];
  logic [1:0]                  pdb_q, tmr_hit, pc_hit, pc_inc;
  logic [1:0]                  cause_q;
  pmw_pkg::pmw_state_t         state_q, state_d;
  pmw_pkg::pmw_pwr_t           pwr_q, pwr_d;
  logic [31:0]                 prdata_q, rdata_d;
  logic                        pready_q, pslverr_q, hit_d;
  logic                        flick_q;
  logic [N-1:0]                fsel_q;
  logic                        setup, wr, doze_req, sleep_req, deep_req;
  logic                        svm_ok, fosc_ok, slow_tick, tmr_run, comp_chg;
  logic                        wake_dio, wake_evt, wake_any;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dio_s1_q <= '0;
      dio_s2_q <= '0;
      dio_s3_q <= '0;
      x_s1_q   <= '0;
      x_s2_q   <= '0;
      x_s3_q   <= '0;
    end else begin
      dio_s1_q <= i_general_io_pin;
      dio_s2_q <= dio_s1_q;
      dio_s3_q <= dio_s2_q;
      x_s1_q   <= {i_pulse, i_comp, i_slow_clk, i_fosc_stable, i_svm_ok};
      x_s2_q   <= x_s1_q;
      x_s3_q   <= x_s2_q;
    end
  end

  assign svm_ok   = x_s2_q[0];
  assign fosc_ok  = x_s2_q[1];
  assign slow_tick = x_s2_q[2] & ~x_s3_q[2] & pwr_q.slow_osc;
  assign tmr_run  = slow_tick & ~(state_q == pmw_pkg::PMW_SLEEP && ctrl_q[pmw_pkg::C_TMROFF]);
  assign comp_chg = x_s2_q[3] ^ x_s3_q[3];
  assign dio_det  = den_q & ((dedge_q & dio_s2_q & ~dio_s3_q) | (~dedge_q & ~dio_s2_q & dio_s3_q));

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign setup     = i_psel & ~i_penable;
  assign wr        = i_psel & i_penable & i_pwrite & pready_q;
  assign doze_req  = wr && i_paddr == pmw_pkg::A_CTRL && i_pwdata[pmw_pkg::C_DOZE];
  assign sleep_req = wr && i_paddr == pmw_pkg::A_CTRL && i_pwdata[pmw_pkg::C_SLEEP];
  assign deep_req  = wr && i_paddr == pmw_pkg::A_CTRL && i_pwdata[pmw_pkg::C_DEEP];
  assign eclr      = (wr && i_paddr == pmw_pkg::A_EPEND) ? i_pwdata[pmw_pkg::NEVT-1:0] : '0;
  assign dclr      = (wr && i_paddr == pmw_pkg::A_DPEND) ? i_pwdata[N-1:0] : '0;

  always_comb begin
    rdata_d = '0;
    hit_d   = 1'b1;
    if (i_paddr == pmw_pkg::A_CTRL) begin
      rdata_d = 32'(ctrl_q);
    end else if (i_paddr == pmw_pkg::A_WEN) begin
      rdata_d = 32'(wen_q);
    end else if (i_paddr == pmw_pkg::A_EPEND) begin
      rdata_d = 32'(epend_q);
    end else if (i_paddr == pmw_pkg::A_DPEND) begin
      rdata_d = 32'(dpend_q);
    end else if (i_paddr == pmw_pkg::A_DEN) begin
      rdata_d = 32'(den_q);
    end else if (i_paddr == pmw_pkg::A_DEDGE) begin
      rdata_d = 32'(dedge_q);
    end else if (i_paddr == pmw_pkg::A_STAT) begin
      rdata_d = 32'({cause_q, 3'(state_q)});
    end else begin
      hit_d = 1'b0;
    end
    for (int k = 0; k < 2; k++) begin
      if (i_paddr == pmw_pkg::A_T0 + 12'(k) * pmw_pkg::A_TSTEP + pmw_pkg::O_CLO) begin
        rdata_d = tcnt_q[k][31:0];
        hit_d   = 1'b1;
      end
      if (i_paddr == pmw_pkg::A_T0 + 12'(k) * pmw_pkg::A_TSTEP + pmw_pkg::O_CHI) begin
        rdata_d = 32'(tcnt_q[k][TW-1:32]);
        hit_d   = 1'b1;
      end
      if (i_paddr == pmw_pkg::A_T0 + 12'(k) * pmw_pkg::A_TSTEP + pmw_pkg::O_MLO) begin
        rdata_d = tcmp_q[k][31:0];
        hit_d   = 1'b1;
      end
      if (i_paddr == pmw_pkg::A_T0 + 12'(k) * pmw_pkg::A_TSTEP + pmw_pkg::O_MHI) begin
        rdata_d = 32'(tcmp_q[k][TW-1:32]);
        hit_d   = 1'b1;
      end
      if (i_paddr == pmw_pkg::A_PC0 + 12'(k) * pmw_pkg::A_PSTEP) begin
        rdata_d = {ptgt_q[k], pcnt_q[k]};
        hit_d   = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= (setup & ~i_pwrite) ? rdata_d : '0;
      pready_q  <= setup;
      pslverr_q <= setup & ~hit_d;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q  <= pmw_pkg::CTRL_RST;
      wen_q   <= '0;
      den_q   <= '0;
      dedge_q <= '0;
    end else if (wr) begin
      if (i_paddr == pmw_pkg::A_CTRL) begin
        ctrl_q <= i_pwdata[pmw_pkg::CTRL_W-1:0] & pmw_pkg::CTRL_KEEP;
      end
      if (i_paddr == pmw_pkg::A_WEN) begin
        wen_q <= i_pwdata[pmw_pkg::NWEN-1:0];
      end
      if (i_paddr == pmw_pkg::A_DEN) begin
        den_q <= i_pwdata[N-1:0];
      end
      if (i_paddr == pmw_pkg::A_DEDGE) begin
        dedge_q <= i_pwdata[N-1:0];
      end
    end
  end

  // ----------------------------------------
  // Wake timers and pulse counters
  // ----------------------------------------
  for (genvar k = 0; k < 2; k++) begin : g_cnt
    assign tmr_hit[k] = tmr_run & (tcnt_q[k] == tcmp_q[k]);
    assign pc_inc[k]  = ctrl_q[pmw_pkg::C_DBNC] ? (slow_tick & x_s2_q[4+k] & ~pdb_q[k])
                                                 : (x_s2_q[4+k] & ~x_s3_q[4+k]);
    assign pc_hit[k]  = pc_inc[k] & (pcnt_q[k] + 16'h0001 == ptgt_q[k]);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        tcnt_q[k] <= '0;
        tcmp_q[k] <= '0;
      end else begin
        if (tmr_run) begin
          tcnt_q[k] <= tcnt_q[k] + 41'h00000000001;
        end
        if (wr && i_paddr == pmw_pkg::A_T0 + 12'(k) * pmw_pkg::A_TSTEP + pmw_pkg::O_MLO) begin
          tcmp_q[k][31:0] <= i_pwdata;
        end
        if (wr && i_paddr == pmw_pkg::A_T0 + 12'(k) * pmw_pkg::A_TSTEP + pmw_pkg::O_MHI) begin
          tcmp_q[k][TW-1:32] <= i_pwdata[TW-33:0];
        end
      end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        pcnt_q[k] <= '0;
        ptgt_q[k] <= '0;
        pdb_q[k]  <= 1'b0;
      end else begin
        if (slow_tick) begin
          pdb_q[k] <= x_s2_q[4+k];
        end
        if (wr && i_paddr == pmw_pkg::A_PC0 + 12'(k) * pmw_pkg::A_PSTEP) begin
          ptgt_q[k] <= i_pwdata[31:16];
          pcnt_q[k] <= '0;
        end else if (pc_inc[k]) begin
          pcnt_q[k] <= pcnt_q[k] + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Pending wake events
  // ----------------------------------------
  assign evt_set = {comp_chg, pc_hit, tmr_hit};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      epend_q <= '0;
      dpend_q <= '0;
    end else begin
      epend_q <= (epend_q & ~eclr) | evt_set;
      dpend_q <= (dpend_q & ~dclr) | dio_det;
    end
  end

  assign wake_dio = wen_q[pmw_pkg::W_DIO] & (|dpend_q);
  assign wake_evt = |(epend_q & wen_q[pmw_pkg::NWEN-1:1]);
  assign wake_any = wake_dio | wake_evt;

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pmw_pkg::PMW_ACTIVE: begin
        if (deep_req) begin
          state_d = wake_dio ? pmw_pkg::PMW_WK_SVM : pmw_pkg::PMW_DEEP;
        end else if (sleep_req) begin
          state_d = wake_any ? pmw_pkg::PMW_WK_SVM : pmw_pkg::PMW_SLEEP;
        end else if (doze_req) begin
          state_d = pmw_pkg::PMW_DOZE;
        end
      end
      pmw_pkg::PMW_DOZE: begin
        if (i_irq) begin
          state_d = pmw_pkg::PMW_ACTIVE;
        end
      end
      pmw_pkg::PMW_SLEEP: begin
        if (wake_any) begin
          state_d = pmw_pkg::PMW_WK_SVM;
        end
      end
      pmw_pkg::PMW_DEEP: begin
        if (wake_dio) begin
          state_d = pmw_pkg::PMW_WK_SVM;
        end
      end
      pmw_pkg::PMW_WK_SVM: begin
        if (svm_ok) begin
          state_d = pmw_pkg::PMW_WK_OSC;
        end
      end
      pmw_pkg::PMW_WK_OSC: begin
        if (fosc_ok) begin
          state_d = pmw_pkg::PMW_WK_PWR;
        end
      end
      pmw_pkg::PMW_WK_PWR: begin
        state_d = pmw_pkg::PMW_ACTIVE;
      end
      default: begin
        state_d = pmw_pkg::PMW_ACTIVE;
      end
    endcase
  end

  always_comb begin
    pwr_d = '0;
    unique case (state_d)
      pmw_pkg::PMW_ACTIVE, pmw_pkg::PMW_DOZE: begin
        pwr_d.dig       = 1'b1;
        pwr_d.ram       = 1'b1;
        pwr_d.radio     = i_radio_req;
        pwr_d.slow_osc  = 1'b1;
        pwr_d.fast_osc  = 1'b1;
        pwr_d.cpu_clk   = state_d == pmw_pkg::PMW_ACTIVE;
        pwr_d.cpu_rst_n = 1'b1;
      end
      pmw_pkg::PMW_SLEEP: begin
        pwr_d.ram      = (state_q == pmw_pkg::PMW_SLEEP) ? ctrl_q[pmw_pkg::C_RET] : i_pwdata[pmw_pkg::C_RET];
        pwr_d.slow_osc = (state_q == pmw_pkg::PMW_SLEEP) ? pwr_q.slow_osc : ~i_pwdata[pmw_pkg::C_OSCOFF];
        pwr_d.pin_hold = 1'b1;
      end
      pmw_pkg::PMW_DEEP: begin
        pwr_d.pin_hold = 1'b1;
      end
      pmw_pkg::PMW_WK_SVM, pmw_pkg::PMW_WK_OSC: begin
        pwr_d.ram      = ctrl_q[pmw_pkg::C_RET];
        pwr_d.slow_osc = 1'b1;
        pwr_d.fast_osc = state_d == pmw_pkg::PMW_WK_OSC;
        pwr_d.pin_hold = 1'b1;
      end
      pmw_pkg::PMW_WK_PWR: begin
        pwr_d.dig      = 1'b1;
        pwr_d.ram      = 1'b1;
        pwr_d.slow_osc = 1'b1;
        pwr_d.fast_osc = 1'b1;
        pwr_d.cpu_clk  = 1'b1;
        pwr_d.pin_hold = 1'b1;
      end
      default: begin
        pwr_d = pmw_pkg::PWR_RST;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= pmw_pkg::PMW_ACTIVE;
      pwr_q   <= pmw_pkg::PWR_RST;
    end else begin
      state_q <= state_d;
      pwr_q   <= pwr_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause_q <= pmw_pkg::CAUSE_POR;
    end else if (state_q == pmw_pkg::PMW_WK_PWR) begin
      cause_q <= pmw_pkg::CAUSE_WAKE;
    end
  end

  // ----------------------------------------
  // Flicker compensation
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flick_q <= 1'b0;
      fsel_q  <= '0;
    end else begin
      flick_q <= ctrl_q[pmw_pkg::C_FEN] &
                 (ctrl_q[pmw_pkg::C_FNOR] ^ (i_radio_rx_active | i_radio_tx_active));
      fsel_q  <= ctrl_q[pmw_pkg::C_FEN] ? (N'(1) << ctrl_q[pmw_pkg::C_FSEL +: 5]) : '0;
    end
  end

  assign o_prdata          = prdata_q;
  assign o_pready          = pready_q;
  assign o_pslverr         = pslverr_q;
  assign o_pwr             = pwr_q;
  assign o_flicker_out     = flick_q;
  assign o_flicker_pin_sel = fsel_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_dig_modes;
    pwr_q.dig |-> state_q inside {pmw_pkg::PMW_ACTIVE, pmw_pkg::PMW_DOZE, pmw_pkg::PMW_WK_PWR};
  endproperty
  a_dig_modes: assert property (p_dig_modes) else $error("logic power outside active");

  property p_dig_off;
    state_q inside {pmw_pkg::PMW_SLEEP, pmw_pkg::PMW_DEEP} |-> !pwr_q.dig && !pwr_q.cpu_rst_n;
  endproperty
  a_dig_off: assert property (p_dig_off) else $error("logic powered in sleep");

  property p_ram_ret;
    state_q == pmw_pkg::PMW_SLEEP |-> pwr_q.ram == ctrl_q[pmw_pkg::C_RET];
  endproperty
  a_ram_ret: assert property (p_ram_ret) else $error("RAM power not per retention");

  property p_radio_off;
    state_q inside {pmw_pkg::PMW_SLEEP, pmw_pkg::PMW_DEEP} |->
      !pwr_q.radio && (state_q != pmw_pkg::PMW_DEEP || !pwr_q.slow_osc);
  endproperty
  a_radio_off: assert property (p_radio_off) else $error("radio powered in sleep");

  property p_doze_exit;
    state_q == pmw_pkg::PMW_DOZE && i_irq |=> state_q == pmw_pkg::PMW_ACTIVE && pwr_q.cpu_clk;
  endproperty
  a_doze_exit: assert property (p_doze_exit) else $error("doze not ended by interrupt");

  property p_hold;
    state_q != pmw_pkg::PMW_ACTIVE && state_q != pmw_pkg::PMW_DOZE |-> pwr_q.pin_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("pins not held");

  property p_osc_restart;
    state_q == pmw_pkg::PMW_SLEEP && wake_any |=> pwr_q.slow_osc ##1 pwr_q.slow_osc;
  endproperty
  a_osc_restart: assert property (p_osc_restart) else $error("slow oscillator not restarted");

  property p_rewake;
    state_q == pmw_pkg::PMW_ACTIVE && sleep_req && !deep_req && wake_any |=> state_q == pmw_pkg::PMW_WK_SVM;
  endproperty
  a_rewake: assert property (p_rewake) else $error("no re-wake on pending event");

  property p_rst_release;
    $rose(pwr_q.cpu_rst_n) |-> $past(pwr_q.fast_osc) && $past(pwr_q.dig);
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("reset released early");

  property p_deep_exit;
    state_q == pmw_pkg::PMW_WK_SVM && $past(state_q) == pmw_pkg::PMW_DEEP |-> $past(wake_dio);
  endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("deep sleep left without pin wake");

  property p_flicker;
    ctrl_q[pmw_pkg::C_FEN] && !ctrl_q[pmw_pkg::C_FNOR] && (i_radio_rx_active || i_radio_tx_active) |=> flick_q;
  endproperty
  a_flicker: assert property (p_flicker) else $error("flicker output wrong");

  property p_cause;
    state_q == pmw_pkg::PMW_WK_PWR |=> cause_q == pmw_pkg::CAUSE_WAKE && state_q == pmw_pkg::PMW_ACTIVE;
  endproperty
  a_cause: assert property (p_cause) else $error("wake cause not recorded");
endmodule

// File: pmw_pkg.sv
// Constants, register map and carrier types of the power-mode and wake-up controller
package pmw_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NDIO  = 20;
  localparam int TMR_W = 41;
  localparam int PC_W  = 16;
  localparam int NEVT  = 5;
  localparam int NWEN  = 6;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_WEN   = 12'h004;
  localparam logic [11:0] A_EPEND = 12'h008;
  localparam logic [11:0] A_DPEND = 12'h00C;
  localparam logic [11:0] A_DEN   = 12'h010;
  localparam logic [11:0] A_DEDGE = 12'h014;
  localparam logic [11:0] A_STAT  = 12'h018;
  localparam logic [11:0] A_T0    = 12'h020;
  localparam logic [11:0] A_TSTEP = 12'h010;
  localparam logic [11:0] O_CLO   = 12'h000;
  localparam logic [11:0] O_CHI   = 12'h004;
  localparam logic [11:0] O_MLO   = 12'h008;
  localparam logic [11:0] O_MHI   = 12'h00C;
  localparam logic [11:0] A_PC0   = 12'h040;
  localparam logic [11:0] A_PSTEP = 12'h004;

  // ----------------------------------------
  // Control, wake-enable and status fields
  // ----------------------------------------
  localparam int C_DOZE   = 0;
  localparam int C_SLEEP  = 1;
  localparam int C_DEEP   = 2;
  localparam int C_RET    = 3;
  localparam int C_OSCOFF = 4;
  localparam int C_TMROFF = 5;
  localparam int C_FNOR   = 6;
  localparam int C_FEN    = 7;
  localparam int C_FSEL   = 8;
  localparam int C_DBNC   = 13;
  localparam int CTRL_W   = 14;
  localparam logic [CTRL_W-1:0] CTRL_KEEP = 14'h3FF8;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 14'h0000;
  localparam int W_DIO    = 0;
  localparam int ST_CAUSE = 3;
  localparam logic [1:0] CAUSE_POR  = 2'h1;
  localparam logic [1:0] CAUSE_WAKE = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    PMW_ACTIVE, PMW_DOZE, PMW_SLEEP, PMW_DEEP, PMW_WK_SVM, PMW_WK_OSC, PMW_WK_PWR
  } pmw_state_t;

  typedef struct packed {
    logic dig;
    logic ram;
    logic radio;
    logic slow_osc;
    logic fast_osc;
    logic cpu_clk;
    logic cpu_rst_n;
    logic pin_hold;
  } pmw_pwr_t;

  localparam pmw_pwr_t PWR_RST = 8'hDC;
endpackage

// File: tb.sv
// Self-checking bench of the power-mode and wake-up controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                          i_clk, i_rst_n, psel, penable, pwrite, irq, rreq, rx, tx, fosc, slow, comp, supply_voltage_monitor;
  logic [11:0]                   paddr;
  logic [31:0]                   pwdata, o_prdata;
  logic [1:0]                    pulse;
  logic [pmw_pkg::NDIO-1:0]      pins, o_sel;
  logic                          o_pready, o_pslverr, o_fout;
  pmw_pkg::pmw_pwr_t             o_pwr;
  logic [32:0]                   expq[$];
  int                            n_mismatch, n_compared, i, idx;
  int unsigned                   r;

  pmw_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_irq(irq), .i_radio_req(rreq), .i_radio_rx_active(rx), .i_radio_tx_active(tx), .i_svm_ok(supply_voltage_monitor),
    .i_fosc_stable(fosc), .i_slow_clk(slow), .i_comp(comp), .i_pulse(pulse), .i_general_io_pin(pins),
    .o_pwr(o_pwr), .o_flicker_out(o_fout), .o_flicker_pin_sel(o_sel));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    slow = 1'b0;
    forever begin
      repeat (8) @(posedge i_clk);
      slow <= ~slow;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task tmo;
    chk(64'h0, 64'h1);
    give_verdict();
  endtask

  // Waits for a power pattern, then compares it
  task wt(input logic [7:0] m, input logic [7:0] v);
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge i_clk);
      if ((o_pwr & m) === v) break;
    end
    chk(o_pwr & m, v);
    if (k == 300) tmo();
    @(posedge i_clk);
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    expq.push_back(e);
    @(posedge i_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    if (k == 20) tmo();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  // Takes the oldest note at every completed access
  always @(posedge i_clk) begin
    if (psel && penable && o_pready === 1'b1) begin
      if (expq.size() == 0) tmo();
      else chk({o_pslverr, o_prdata}, expq.pop_front());
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {i_rst_n, psel, penable, pwrite, irq, rreq, rx, tx, comp} = '0;
    {paddr, pwdata, pulse, pins} = '0;
    fosc = 1'b1;
    supply_voltage_monitor = 1'b1;
    void'($urandom(72));
    repeat (12) @(posedge i_clk);
    @(negedge i_clk);
    chk(o_pwr, pmw_pkg::PWR_RST);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(pmw_pkg::A_STAT, 33'h08);
    rd(12'hFFC, {1'b1, 32'h0});
    wr(pmw_pkg::A_CTRL, 32'h1);
    wt(8'h06, 8'h02);
    rd(pmw_pkg::A_STAT, 33'h09);
    irq <= 1'b1;
    @(posedge i_clk);
    irq <= 1'b0;
    wt(8'hFF, 8'hDE);
    wr(pmw_pkg::A_DEN, 32'h8);
    wr(pmw_pkg::A_DEDGE, 32'h8);
    wr(pmw_pkg::A_WEN, 32'h1);
    fosc <= 1'b0;
    wr(pmw_pkg::A_CTRL, 32'h1A);
    wt(8'hFB, 8'h41);
    comp <= 1'b1;
    repeat (20) @(posedge i_clk);
    wt(8'hFB, 8'h41);
    supply_voltage_monitor <= 1'b0;
    pins[3] <= 1'b1;
    wt(8'h9A, 8'h10);
    repeat (10) @(posedge i_clk);
    wt(8'h9A, 8'h10);
    supply_voltage_monitor <= 1'b1;
    wt(8'h9A, 8'h18);
    repeat (10) @(posedge i_clk);
    wt(8'h9A, 8'h18);
    fosc <= 1'b1;
    wt(8'hFF, 8'hDE);
    rd(pmw_pkg::A_STAT, 33'h10);
    rd(pmw_pkg::A_DPEND, 33'h8);
    rd(pmw_pkg::A_EPEND, 33'h13);
    wr(pmw_pkg::A_CTRL, 32'h2);
    wt(8'h02, 8'h00);
    wt(8'h02, 8'h02);
    wr(pmw_pkg::A_DPEND, 32'h8);
    wr(pmw_pkg::A_EPEND, 32'h1F);
    pins[3] <= 1'b0;
    repeat (6) @(posedge i_clk);
    rd(pmw_pkg::A_DPEND, 33'h0);
    wr(pmw_pkg::A_WEN, 32'h21);
    wr(pmw_pkg::A_CTRL, 32'h4);
    wt(8'hFB, 8'h01);
    comp <= 1'b0;
    repeat (20) @(posedge i_clk);
    wt(8'hFB, 8'h01);
    pins[3] <= 1'b1;
    wt(8'hFF, 8'hDE);
    wr(pmw_pkg::A_DPEND, 32'h8);
    wr(pmw_pkg::A_EPEND, 32'h1F);
    wr(pmw_pkg::A_PC0, 32'h0003_0000);
    wr(pmw_pkg::A_WEN, 32'h8);
    wr(pmw_pkg::A_CTRL, 32'h12);
    for (i = 0; i < 3; i++) begin
      wt(8'hFB, 8'h01);
      pulse[0] <= 1'b1;
      repeat (4) @(posedge i_clk);
      pulse[0] <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    wt(8'hFF, 8'hDE);
    rd(pmw_pkg::A_PC0, 33'h0003_0003);
    for (i = 0; i < 8; i++) begin
      r = $urandom;
      idx = int'(r % 20);
      rx <= r[0];
      tx <= r[1];
      rreq <= r[2];
      wr(pmw_pkg::A_CTRL, 32'((idx << 8) | 32'h80 | (r[3] << 6)));
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk(o_fout, r[3] ^ (r[0] | r[1]));
      chk(o_sel, 20'h1 << idx);
      chk(o_pwr.radio, r[2]);
      @(posedge i_clk);
    end
    wr(pmw_pkg::A_CTRL, 32'h0);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk(o_sel, 20'h0);
    give_verdict();
  end
endmodule
